// ===== rtl/host_port_pkg.sv
// Shared constants and carrier types for the host access port
package host_port_pkg;
	localparam int ADDR_W = 16;
	localparam int PIN_ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam logic [1:0] IDX_MODE = 2'h0;
	localparam logic [1:0] IDX_ADDR_HI = 2'h1;
	localparam logic [1:0] IDX_ADDR_LO = 2'h2;
	localparam logic [1:0] IDX_DATA = 2'h3;
	localparam int MODE_INDIRECT_BIT = 0;
	localparam int MODE_AUTO_INC_BIT = 1;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [15:0] MODE_CTRL_ADDR = 16'h0000;
	localparam logic [7:0] OP_WRITE = 8'hF0;
	localparam logic [7:0] OP_READ = 8'h0F;
	localparam logic [5:0] SPI_HDR_BITS = 6'h18;
	localparam logic [5:0] SPI_FRAME_BITS = 6'h20;
	localparam logic [15:0] ADDR_STEP = 16'h0001;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} mem_rsp_t;
endpackage : host_port_pkg

// ===== rtl/spi_slave_port.sv
// Serial slave front end: frame capture, opcode decode and read-data shift out
`timescale 1ns/1ps
module spi_slave_port
	import host_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic enable_i,
	input wire logic sclk_i,
	input wire logic ss_n_i,
	input wire logic mosi_i,
	input wire host_port_pkg::mem_rsp_t rsp_i,
	output host_port_pkg::mem_req_t req_o,
	output logic miso_o,
	output logic miso_oe_o
);
	typedef struct packed {
		logic [2:0] sck_s;
		logic [1:0] ss_s;
		logic [1:0] mosi_s;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic [7:0] rbyte;
		logic miso;
		logic oe;
		logic rdf;
		mem_req_t req;
	} spi_st_t;

	spi_st_t r_r;
	spi_st_t r_nxt;
	logic active;
	logic rise;
	logic fall;
	logic [31:0] sh_in;

	assign active = enable_i && !r_r.ss_s[1];
	// Only edges are used, so either idle clock level works
	assign rise = r_r.sck_s[1] && !r_r.sck_s[2];
	assign fall = !r_r.sck_s[1] && r_r.sck_s[2];
	assign sh_in = {r_r.sh[30:0], r_r.mosi_s[1]};

	always_comb begin
		r_nxt = r_r;
		r_nxt.sck_s = {r_r.sck_s[1:0], sclk_i};
		r_nxt.ss_s = {r_r.ss_s[0], ss_n_i};
		r_nxt.mosi_s = {r_r.mosi_s[0], mosi_i};
		r_nxt.req.rd = 1'b0;
		r_nxt.req.wr = 1'b0;
		if (rsp_i.valid) begin
			r_nxt.rbyte = rsp_i.data;
		end
		if (!active) begin
			// Select released early: partial frame is dropped
			r_nxt.cnt = 6'h00;
			r_nxt.miso = 1'b0;
			r_nxt.oe = 1'b0;
			r_nxt.rdf = 1'b0;
		end else begin
			r_nxt.oe = 1'b1;
			if (rise && r_r.cnt < SPI_FRAME_BITS) begin
				r_nxt.sh = sh_in;
				r_nxt.cnt = r_r.cnt + 6'h01;
				if (r_r.cnt == SPI_HDR_BITS - 6'h01 && sh_in[23:16] == OP_READ) begin
					r_nxt.req.rd = 1'b1;
					r_nxt.req.addr = sh_in[15:0];
					r_nxt.rdf = 1'b1;
				end
				if (r_r.cnt == SPI_FRAME_BITS - 6'h01 && sh_in[31:24] == OP_WRITE) begin
					r_nxt.req.wr = 1'b1;
					r_nxt.req.addr = sh_in[23:8];
					r_nxt.req.wdata = sh_in[7:0];
				end
			end
			if (fall) begin
				// Only a read frame returns data; a stale byte never leaks into other frames
				if (r_r.rdf && r_r.cnt >= SPI_HDR_BITS && r_r.cnt < SPI_FRAME_BITS) begin
					r_nxt.miso = r_r.rbyte[3'h7 - r_r.cnt[2:0]];
				end else begin
					r_nxt.miso = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r_r <= '0;
			r_r.ss_s <= 2'h3;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign req_o = r_r.req;
	assign miso_o = r_r.miso;
	assign miso_oe_o = r_r.oe;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_spi_write_frame: assert property (r_r.req.wr |-> r_r.sh[31:24] == OP_WRITE && r_r.cnt == SPI_FRAME_BITS)
		else $error("write issued without full write frame");
	a_spi_read_frame: assert property (r_r.req.rd |-> r_r.sh[23:16] == OP_READ && r_r.cnt == SPI_HDR_BITS)
		else $error("read issued off header boundary");
	a_spi_shift_rise: assert property (active && rise && r_r.cnt < SPI_FRAME_BITS
		|=> r_r.cnt == $past(r_r.cnt) + 6'h01 && r_r.sh[0] == $past(r_r.mosi_s[1]))
		else $error("bit not sampled on rising clock");
	a_spi_out_fall: assert property (active && $past(active) && $changed(r_r.miso) |-> $past(fall))
		else $error("output changed away from falling clock");
	a_spi_discard: assert property (!active |=> r_r.cnt == 6'h00 && !r_r.oe)
		else $error("partial frame not dropped");
	a_spi_nonread_low: assert property (!r_r.rdf |-> !r_r.miso)
		else $error("data driven outside a read frame");
	c_spi_write: cover property (r_r.req.wr);
	c_spi_read: cover property (r_r.req.rd ##[1:40] (fall && r_r.cnt == SPI_HDR_BITS));
endmodule : spi_slave_port

// ===== rtl/host_bus_interface.sv
// Host access port: direct and indirect parallel bus plus serial slave mode
// Contract
// - Direct bus: 15-bit address, byte data, interrupt
// - Indirect bus: 2-bit address, same strobes
// - Indirect map: mode, address high, low, data
// - Indirect address high byte is most significant
// - Auto-increment bumps address on window access
// - Serial select repurposes three upper address pins
// - Serial slave accepts modes zero and three
// - Sample on rising, drive on falling clock
// - Frame: opcode, two address bytes, data
// - All fields shifted most significant bit first
// - Opcode F0 writes, 0F reads, others ignored
`timescale 1ns/1ps
module host_bus_interface
	import host_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic spi_en_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [host_port_pkg::PIN_ADDR_W-1:0] addr_i,
	input wire logic [host_port_pkg::DATA_W-1:0] data_i,
	output logic [host_port_pkg::DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic int_n_o,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic irq_i,
	output host_port_pkg::mem_req_t mem_req_o,
	input wire logic [host_port_pkg::DATA_W-1:0] mem_rdata_i
);
	typedef enum {PEND_NONE, PEND_PAR, PEND_SPI} pend_t;

	typedef struct packed {
		logic [1:0] en_s;
		logic [1:0] cs_s;
		logic [1:0] rd_s;
		logic [1:0] wr_s;
		logic [PIN_ADDR_W-1:0] a_s1;
		logic [PIN_ADDR_W-1:0] a_s2;
		logic [DATA_W-1:0] d_s1;
		logic [DATA_W-1:0] d_s2;
		logic rd_act;
		logic wr_act;
		logic [PIN_ADDR_W-1:0] wa;
		logic [DATA_W-1:0] wd;
		logic [DATA_W-1:0] mode;
		logic [ADDR_W-1:0] iaddr;
		mem_req_t req;
		pend_t pend;
		mem_rsp_t srsp;
		logic [DATA_W-1:0] dout;
		logic doe;
		logic int_n;
	} st_t;

	st_t r_r;
	st_t r_nxt;
	mem_req_t spi_req;
	logic spi_mode;
	logic ind;
	logic rd_now;
	logic wr_now;
	logic rd_start;
	logic wr_end;
	logic [1:0] idx;
	logic win_hit;

	// Parallel strobes are ignored while the serial strap is high, except that a write strobe already low when it rises commits then
	assign spi_mode = r_r.en_s[1];
	assign ind = r_r.mode[MODE_INDIRECT_BIT];
	assign rd_now = !spi_mode && !r_r.cs_s[1] && !r_r.rd_s[1];
	assign wr_now = !spi_mode && !r_r.cs_s[1] && !r_r.wr_s[1];
	assign rd_start = rd_now && !r_r.rd_act;
	assign wr_end = !wr_now && r_r.wr_act;
	assign idx = rd_start ? r_r.a_s2[1:0] : r_r.wa[1:0];
	assign win_hit = (rd_start || wr_end) && ind && idx == IDX_DATA;

	always_comb begin
		logic [ADDR_W-1:0] tgt;
		tgt = '0;
		r_nxt = r_r;
		r_nxt.en_s = {r_r.en_s[0], spi_en_i};
		r_nxt.cs_s = {r_r.cs_s[0], cs_n_i};
		r_nxt.rd_s = {r_r.rd_s[0], rd_n_i};
		r_nxt.wr_s = {r_r.wr_s[0], wr_n_i};
		r_nxt.a_s1 = addr_i;
		r_nxt.a_s2 = r_r.a_s1;
		r_nxt.d_s1 = data_i;
		r_nxt.d_s2 = r_r.d_s1;
		r_nxt.rd_act = rd_now;
		r_nxt.wr_act = wr_now;
		r_nxt.doe = rd_now;
		r_nxt.int_n = !irq_i;
		r_nxt.req.rd = 1'b0;
		r_nxt.req.wr = 1'b0;
		r_nxt.pend = PEND_NONE;
		r_nxt.srsp.valid = 1'b0;
		// Write data is held while the strobe is low; commit at release
		if (wr_now) begin
			r_nxt.wa = r_r.a_s2;
			r_nxt.wd = r_r.d_s2;
		end
		// Core answers in the same cycle as the read request
		case (r_r.pend)
			PEND_PAR: r_nxt.dout = mem_rdata_i;
			PEND_SPI: begin
				r_nxt.srsp.valid = 1'b1;
				r_nxt.srsp.data = mem_rdata_i;
			end
			default: ;
		endcase
		if (rd_start || wr_end) begin
			tgt = ind ? r_r.iaddr : {1'b0, (rd_start ? r_r.a_s2 : r_r.wa)};
			if (ind && idx != IDX_DATA) begin
				// Indexes other than data reach only the three local bytes
				case (idx)
					IDX_MODE: begin
						if (rd_start) r_nxt.dout = r_r.mode;
						else r_nxt.mode = r_r.wd;
					end
					IDX_ADDR_HI: begin
						if (rd_start) r_nxt.dout = r_r.iaddr[15:8];
						else r_nxt.iaddr[15:8] = r_r.wd;
					end
					IDX_ADDR_LO: begin
						if (rd_start) r_nxt.dout = r_r.iaddr[7:0];
						else r_nxt.iaddr[7:0] = r_r.wd;
					end
					default: ;
				endcase
			end else if (tgt == MODE_CTRL_ADDR) begin
				if (rd_start) r_nxt.dout = r_r.mode;
				else r_nxt.mode = r_r.wd;
			end else begin
				r_nxt.req.rd = rd_start;
				r_nxt.req.wr = wr_end;
				r_nxt.req.addr = tgt;
				r_nxt.req.wdata = r_r.wd;
				r_nxt.pend = rd_start ? PEND_PAR : PEND_NONE;
			end
			if (win_hit && r_r.mode[MODE_AUTO_INC_BIT]) begin
				r_nxt.iaddr = r_r.iaddr + ADDR_STEP;
			end
		end
		// A serial request can still arrive the cycle after the strap drops; a serial memory request then replaces a parallel read of that cycle
		if (spi_req.rd || spi_req.wr) begin
			if (spi_req.addr == MODE_CTRL_ADDR) begin
				if (spi_req.wr) r_nxt.mode = spi_req.wdata;
				r_nxt.srsp.valid = spi_req.rd;
				r_nxt.srsp.data = r_r.mode;
			end else begin
				r_nxt.req = spi_req;
				r_nxt.pend = spi_req.rd ? PEND_SPI : PEND_NONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r_r <= '0;
			r_r.cs_s <= 2'h3;
			r_r.rd_s <= 2'h3;
			r_r.wr_s <= 2'h3;
			r_r.mode <= MODE_RESET;
			r_r.pend <= PEND_NONE;
			r_r.int_n <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Pins A14..A12 carry clock, select and data in in serial mode; data out leaves on miso_o
	spi_slave_port spi_slave_port_i (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.enable_i(spi_mode),
		.sclk_i(addr_i[14]),
		.ss_n_i(addr_i[13]),
		.mosi_i(addr_i[12]),
		.rsp_i(r_r.srsp),
		.req_o(spi_req),
		.miso_o(miso_o),
		.miso_oe_o(miso_oe_o)
	);

	assign data_o = r_r.dout;
	assign data_oe_o = r_r.doe;
	assign int_n_o = r_r.int_n;
	assign mem_req_o = r_r.req;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_int_follows_irq: assert property (irq_i |=> !int_n_o)
		else $error("interrupt pin did not follow core request");
	a_direct_read: assert property (rd_start && !ind && r_r.a_s2 != PIN_ADDR_W'(0)
		|=> mem_req_o.rd && mem_req_o.addr == {1'b0, $past(r_r.a_s2)})
		else $error("direct read address wrong");
	a_window_read: assert property (rd_start && ind && r_r.a_s2[1:0] == IDX_DATA && r_r.iaddr != 16'h0000
		|=> mem_req_o.rd && mem_req_o.addr == $past(r_r.iaddr))
		else $error("window read used wrong address");
	a_addr_hi_load: assert property (wr_end && ind && r_r.wa[1:0] == IDX_ADDR_HI
		|=> r_r.iaddr[15:8] == $past(r_r.wd) && !mem_req_o.wr)
		else $error("address high byte not loaded");
	a_local_read: assert property (rd_start && ind && r_r.a_s2[1:0] == IDX_ADDR_LO
		|=> data_o == $past(r_r.iaddr[7:0]) && !mem_req_o.rd)
		else $error("indirect local read wrong");
	a_auto_incr: assert property (win_hit && r_r.mode[MODE_AUTO_INC_BIT]
		|=> r_r.iaddr == $past(r_r.iaddr) + ADDR_STEP)
		else $error("window access did not advance address");
	a_serial_quiet: assert property (spi_mode && $past(spi_mode) |-> !data_oe_o && !rd_start)
		else $error("parallel port active in serial mode");
	c_window_incr: cover property (win_hit && r_r.mode[MODE_AUTO_INC_BIT]);
	c_direct_write: cover property (wr_end && !ind);
endmodule : host_bus_interface

// ===== dv/spi_host_model.sv
// Serial master model: sends one frame in mode 0 or 3 and gathers the returned bits
`timescale 1ns/1ps
module spi_host_model (
	input wire logic miso_i,
	output logic sclk_o,
	output logic ss_n_o,
	output logic mosi_o
);
	initial begin
		sclk_o = 1'h0;
		ss_n_o = 1'h1;
		mosi_o = 1'h0;
	end

	// Half period of 32 ns gives the slave eight core cycles per phase
	task automatic frame(input logic cpol, input logic [31:0] tx, input int nbits,
		output logic [7:0] rx);
		logic [31:0] sh;
		sh = '0;
		sclk_o = cpol;
		#40;
		ss_n_o = 1'h0;
		#40;
		for (int i = 0; i < nbits; i++) begin
			sclk_o = 1'h0;
			mosi_o = tx[31-i];
			#32;
			sclk_o = 1'h1;
			sh = {sh[30:0], miso_i};
			#32;
		end
		sclk_o = cpol;
		#32;
		ss_n_o = 1'h1;
		// Released data line must not keep showing the last bit
		mosi_o = ~mosi_o;
		rx = sh[7:0];
		#40;
	endtask : frame
endmodule : spi_host_model

// ===== dv/host_bus_interface_tb_top.sv
// Self-checking bench for the host access port: parallel, indirect and serial traffic
`timescale 1ns/1ps
module host_bus_interface_tb_top;
	import host_port_pkg::*;
	logic clk_i, srst_i, spi_en_i, cs_n_i, rd_n_i, wr_n_i, irq_i;
	logic [14:0] par_addr;
	logic [14:0] addr_i;
	logic [7:0] data_i, data_o, mem_rdata_i, rd;
	logic data_oe_o, int_n_o, miso_o, miso_oe_o, sclk, ss_n, mosi, spi_miso;
	mem_req_t mem_req_o;
	logic [7:0] mem [256];
	logic [15:0] wr_addr_q;
	int err_count, checked;

	assign addr_i = spi_en_i ? {sclk, ss_n, mosi, par_addr[11:0]} : par_addr;
	assign mem_rdata_i = mem[mem_req_o.addr[7:0]];
	assign spi_miso = miso_oe_o ? miso_o : ~miso_o;

	host_bus_interface host_bus_interface_i (.clk_i(clk_i), .srst_i(srst_i),
		.spi_en_i(spi_en_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
		.addr_i(addr_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
		.int_n_o(int_n_o), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .irq_i(irq_i),
		.mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i));
	spi_host_model spi_host_model_i (.miso_i(spi_miso), .sclk_o(sclk), .ss_n_o(ss_n),
		.mosi_o(mosi));

	always @(posedge clk_i) begin
		if (mem_req_o.wr === 1'h1) begin
			mem[mem_req_o.addr[7:0]] <= mem_req_o.wdata;
			wr_addr_q <= mem_req_o.addr;
		end
	end

	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic final_report();
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	// One strobe cycle of 80 ns, read data taken while the strobe is still low
	task automatic bus(input logic wr, input logic [14:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_i);
		par_addr = a;
		data_i = d;
		cs_n_i = 1'h0;
		rd_n_i = wr;
		wr_n_i = ~wr;
		repeat (20) @(negedge clk_i);
		q = data_o;
		if (!wr) check("data_oe", 16'h1, data_oe_o);
		cs_n_i = 1'h1;
		rd_n_i = 1'h1;
		wr_n_i = 1'h1;
		repeat (10) @(negedge clk_i);
		check("data_oe_idle", 16'h0, data_oe_o);
	endtask : bus

	initial begin
		#100000;
		err_count++;
		final_report();
	end

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		{spi_en_i, irq_i, srst_i} = 3'h1;
		{cs_n_i, rd_n_i, wr_n_i} = 3'h7;
		par_addr = 15'h0000;
		data_i = 8'h00;
		wr_addr_q = 16'h0000;
		repeat (12) @(negedge clk_i);
		srst_i = 1'h0;
		bus(1'h0, 15'h0000, 8'h00, rd);
		check("mode_reset", 16'h00, rd);
		bus(1'h1, 15'h0401, 8'h5A, rd);
		check("direct_wr_addr", 16'h0401, wr_addr_q);
		bus(1'h0, 15'h0401, 8'h00, rd);
		check("direct_rd", 16'h5A, rd);
		// Upper address pins held low for the remaining parallel accesses
		bus(1'h1, {13'h0, IDX_MODE}, 8'h03, rd);
		bus(1'h1, {13'h0, IDX_ADDR_HI}, 8'h04, rd);
		bus(1'h1, {13'h0, IDX_ADDR_LO}, 8'h02, rd);
		bus(1'h1, {13'h0, IDX_DATA}, 8'hC3, rd);
		check("window_wr_addr", 16'h0402, wr_addr_q);
		bus(1'h0, {13'h0, IDX_ADDR_LO}, 8'h00, rd);
		check("addr_lo_inc", 16'h03, rd);
		bus(1'h1, {13'h0, IDX_ADDR_LO}, 8'h01, rd);
		bus(1'h0, {13'h0, IDX_DATA}, 8'h00, rd);
		check("window_rd0", 16'h5A, rd);
		bus(1'h0, {13'h0, IDX_DATA}, 8'h00, rd);
		check("window_rd1", 16'hC3, rd);
		bus(1'h0, {13'h0, IDX_ADDR_HI}, 8'h00, rd);
		check("addr_hi", 16'h04, rd);
		bus(1'h1, {13'h0, IDX_MODE}, 8'h01, rd);
		bus(1'h1, {13'h0, IDX_ADDR_LO}, 8'h01, rd);
		bus(1'h0, {13'h0, IDX_DATA}, 8'h00, rd);
		check("window_rd2", 16'h5A, rd);
		bus(1'h0, {13'h0, IDX_ADDR_LO}, 8'h00, rd);
		check("addr_lo_hold", 16'h01, rd);
		spi_en_i = 1'h1;
		repeat (5) @(negedge clk_i);
		for (int m = 0; m < 2; m++) begin
			spi_host_model_i.frame(m[0], {OP_WRITE, 16'h0010, 8'h3C ^ m[7:0]}, 32, rd);
			check("spi_wr_addr", 16'h0010, wr_addr_q);
			check("miso_oe_idle", 16'h0, miso_oe_o);
			spi_host_model_i.frame(m[0], {OP_READ, 16'h0010, 8'h00}, 32, rd);
			check("spi_rd", {8'h00, 8'h3C ^ m[7:0]}, {8'h00, rd});
		end
		// Mode control is also reachable at internal address zero over the serial link
		spi_host_model_i.frame(1'h1, {OP_READ, 16'h0000, 8'h00}, 32, rd);
		check("spi_mode_rd", 16'h01, rd);
		spi_host_model_i.frame(1'h0, {8'h55, 16'h0011, 8'h77}, 32, rd);
		check("bad_opcode", 16'h00, mem[8'h11]);
		check("bad_opcode_miso", 16'h00, rd);
		spi_host_model_i.frame(1'h0, {OP_WRITE, 16'h0012, 8'h66}, 31, rd);
		check("short_frame", 16'h00, mem[8'h12]);
		irq_i = 1'h1;
		repeat (3) @(negedge clk_i);
		check("int_low", 16'h0, int_n_o);
		irq_i = 1'h0;
		repeat (3) @(negedge clk_i);
		check("int_high", 16'h1, int_n_o);
		final_report();
	end
endmodule : host_bus_interface_tb_top
